// ### ecr_pkg.sv
/*
  constants for the mac configuration register bank: offsets, field positions, masks, reset values.
  assumes a 10-bit host address and 32-bit host data.
*/
package ecr_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 32;
  localparam int GAP_W = 8;
  localparam logic [9:0] OFF_RX0 = 10'h200;
  localparam logic [9:0] OFF_RX1 = 10'h240;
  localparam logic [9:0] OFF_TX = 10'h280;
  localparam logic [9:0] OFF_FLOW = 10'h2C0;
  localparam logic [9:0] OFF_MODE = 10'h300;
  localparam logic [9:0] OFF_PHY = 10'h320;
  localparam logic [9:0] OFF_MGMT = 10'h340;
  localparam logic [9:0] OFF_UNI0 = 10'h380;
  localparam logic [9:0] OFF_UNI1 = 10'h384;
  localparam logic [9:0] OFF_TAB0 = 10'h388;
  localparam logic [9:0] OFF_TAB1 = 10'h38C;
  localparam logic [9:0] OFF_FMODE = 10'h390;
  localparam int BIT_CTRL_LEN = 24;
  localparam int BIT_LT = 25;
  localparam int BIT_IFG = 25;
  localparam int BIT_HD = 26;
  localparam int BIT_VLAN = 27;
  localparam int BIT_EN = 28;
  localparam int BIT_FCS = 29;
  localparam int BIT_JUMBO = 30;
  localparam int BIT_RST = 31;
  localparam int BIT_RXFLOW = 29;
  localparam int BIT_TXFLOW = 30;
  localparam int PAUSE_HI_W = 16;
  // bit31 is excluded so the self-clearing resets always read back zero
  localparam logic [31:0] MASK_RX1 = 32'h7F00_FFFF;
  localparam logic [31:0] MASK_TX = 32'h7E00_0000;
  localparam logic [31:0] MASK_FLOW = 32'h6000_0000;
  localparam logic [31:0] DEF_RX0 = 32'h0000_0000;
  localparam logic [31:0] DEF_RX1 = 32'h1000_0000;
  localparam logic [31:0] DEF_TX = 32'h1000_0000;
  localparam logic [31:0] DEF_FLOW = 32'h0000_0000;
  localparam logic [31:0] DEF_ZERO = 32'h0000_0000;
endpackage

// ### ecr_upd_if.sv
/*
  carrier between the register bank and its gap-gated apply stages.
  assumes one clock domain; the bank drives staged value, gap and force load.
*/
interface ecr_upd_if #(parameter int W = 32);
  logic [W-1:0] staged;
  logic gap;
  logic force_load;
  logic [W-1:0] active;
  modport src (output staged, output gap, output force_load, input active);
  modport dst (input staged, input gap, input force_load, output active);
endinterface

// ### ecr_apply.sv
/*
  gap-gated copy of a staged configuration word into the value the data path sees.
  assumes gap is high only between frames; force_load restores the default at once.
*/
module ecr_apply #(
  parameter int W = 32,
  parameter logic [W-1:0] DEFAULT = '0
) (
  input wire logic ref_clk,
  input wire logic rst,
  ecr_upd_if.dst upd
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upd.active <= DEFAULT;
    end else if (upd.force_load) begin
      upd.active <= DEFAULT;
    end else if (upd.gap) begin
      upd.active <= upd.staged;
    end
  end
endmodule

// ### ecr_gap_sample.sv
/*
  captures the client gap delay at each transmit frame start in full duplex with gap adjust on; otherwise loads zero.
  assumes frame_start is a one-cycle pulse on ref_clk.
*/
module ecr_gap_sample #(parameter int DW = 8) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic frame_start,
  input wire logic adjust_on,
  input wire logic half_duplex,
  input wire logic [DW-1:0] delay_in,
  output logic [DW-1:0] gap_delay
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gap_delay <= '0;
    end else if (clear) begin
      gap_delay <= '0;
    end else if (frame_start) begin
      // adjustment has no meaning in half duplex, so fall back to the nominal gap
      gap_delay <= (adjust_on && !half_duplex) ? delay_in : '0;
    end
  end
endmodule

// ### ecr_mac_cfg.sv
/*
  mac configuration and address filter register bank on the host interface.
  assumes host strobes are one-cycle pulses synchronous to ref_clk and that the
  receive and transmit paths flag frame activity so receive, transmit and filter writes other than soft resets land only in gaps.
*/
module ecr_mac_cfg
  import ecr_pkg::*;
#(
  parameter logic [31:0] RX0_DEFAULT = DEF_RX0,
  parameter logic [31:0] RX1_DEFAULT = DEF_RX1,
  parameter logic [31:0] TX_DEFAULT = DEF_TX,
  parameter logic [31:0] FLOW_DEFAULT = DEF_FLOW
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [DATA_W-1:0] host_wdata,
  output logic [DATA_W-1:0] host_rdata,
  output logic host_rd_valid,
  input wire logic rx_frame_active,
  input wire logic tx_frame_active,
  input wire logic tx_frame_start,
  input wire logic [GAP_W-1:0] client_gap_delay_value,
  output logic [47:0] pause_station_address,
  output logic control_frame_length_check_off,
  output logic length_type_check_off,
  output logic receive_half_duplex,
  output logic receive_tagged_frames_on,
  output logic receiver_on,
  output logic receive_pass_checksum,
  output logic receive_oversize_frames_on,
  output logic receiver_soft_reset,
  output logic transmit_gap_adjust_on,
  output logic transmit_half_duplex,
  output logic transmit_tagged_frames_on,
  output logic transmitter_on,
  output logic transmit_client_checksum,
  output logic transmit_oversize_frames_on,
  output logic transmitter_soft_reset,
  output logic [GAP_W-1:0] tx_gap_delay,
  output logic rx_flow_ctrl_on,
  output logic tx_flow_ctrl_on,
  output logic [47:0] station_unicast_address,
  output logic [31:0] extra_table_word0,
  output logic [31:0] extra_table_word1,
  output logic [31:0] filter_mode,
  output logic [31:0] mac_mode,
  output logic [31:0] phy_link,
  output logic [31:0] mgmt
);
  logic [31:0] rx0;
  logic [31:0] rx1;
  logic [31:0] tx;
  logic [31:0] flow;
  logic [31:0] mode;
  logic [31:0] phy;
  logic [31:0] mg;
  logic [31:0] uni0;
  logic [31:0] uni1;
  logic [31:0] tab0;
  logic [31:0] tab1;
  logic [31:0] fmode;
  logic wr_rx_rst;
  logic wr_tx_rst;
  logic hit;
  logic [31:0] next_rdata;

  ecr_upd_if #(.W(64)) rx_upd ();
  ecr_upd_if #(.W(64)) tx_upd ();
  ecr_upd_if #(.W(160)) flt_upd ();

  assign wr_rx_rst = host_wr && host_addr == OFF_RX1 && host_wdata[BIT_RST];
  assign wr_tx_rst = host_wr && host_addr == OFF_TX && host_wdata[BIT_RST];

  // receiver words: a soft reset restores both to defaults
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rx0 <= RX0_DEFAULT;
      rx1 <= RX1_DEFAULT & MASK_RX1;
    end else if (wr_rx_rst) begin
      rx0 <= RX0_DEFAULT;
      rx1 <= RX1_DEFAULT & MASK_RX1;
    end else if (host_wr && host_addr == OFF_RX0) begin
      rx0 <= host_wdata;
    end else if (host_wr && host_addr == OFF_RX1) begin
      rx1 <= host_wdata & MASK_RX1;
    end
  end

  // transmitter word and flow control travel with the transmit path
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx <= TX_DEFAULT & MASK_TX;
    end else if (wr_tx_rst) begin
      tx <= TX_DEFAULT & MASK_TX;
    end else if (host_wr && host_addr == OFF_TX) begin
      tx <= host_wdata & MASK_TX;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      flow <= FLOW_DEFAULT & MASK_FLOW;
    end else if (host_wr && host_addr == OFF_FLOW) begin
      flow <= host_wdata & MASK_FLOW;
    end
  end

  // host interface level settings, not tied to frame boundaries
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mode <= DEF_ZERO;
      phy <= DEF_ZERO;
      mg <= DEF_ZERO;
    end else if (host_wr) begin
      if (host_addr == OFF_MODE) begin
        mode <= host_wdata;
      end
      if (host_addr == OFF_PHY) begin
        phy <= host_wdata;
      end
      if (host_addr == OFF_MGMT) begin
        mg <= host_wdata;
      end
    end
  end

  // address filter words
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      uni0 <= DEF_ZERO;
      uni1 <= DEF_ZERO;
      tab0 <= DEF_ZERO;
      tab1 <= DEF_ZERO;
      fmode <= DEF_ZERO;
    end else if (host_wr) begin
      if (host_addr == OFF_UNI0) begin
        uni0 <= host_wdata;
      end
      if (host_addr == OFF_UNI1) begin
        uni1 <= host_wdata;
      end
      if (host_addr == OFF_TAB0) begin
        tab0 <= host_wdata;
      end
      if (host_addr == OFF_TAB1) begin
        tab1 <= host_wdata;
      end
      if (host_addr == OFF_FMODE) begin
        fmode <= host_wdata;
      end
    end
  end

  // reset pulses are registered so they line up with the forced reload
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      receiver_soft_reset <= 1'b0;
      transmitter_soft_reset <= 1'b0;
    end else begin
      receiver_soft_reset <= wr_rx_rst;
      transmitter_soft_reset <= wr_tx_rst;
    end
  end

  // read path: unmapped offsets answer zero
  always_comb begin
    hit = 1'b1;
    next_rdata = DEF_ZERO;
    unique case (host_addr)
      OFF_RX0: next_rdata = rx0;
      OFF_RX1: next_rdata = rx1;
      OFF_TX: next_rdata = tx;
      OFF_FLOW: next_rdata = flow;
      OFF_MODE: next_rdata = mode;
      OFF_PHY: next_rdata = phy;
      OFF_MGMT: next_rdata = mg;
      OFF_UNI0: next_rdata = uni0;
      OFF_UNI1: next_rdata = uni1;
      OFF_TAB0: next_rdata = tab0;
      OFF_TAB1: next_rdata = tab1;
      OFF_FMODE: next_rdata = fmode;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      host_rdata <= DEF_ZERO;
      host_rd_valid <= 1'b0;
    end else begin
      host_rd_valid <= host_rd;
      if (host_rd) begin
        host_rdata <= hit ? next_rdata : DEF_ZERO;
      end
    end
  end

  // gap-gated apply stages
  assign rx_upd.staged = {rx1, rx0};
  assign rx_upd.gap = !rx_frame_active;
  assign rx_upd.force_load = receiver_soft_reset;
  assign tx_upd.staged = {flow, tx};
  assign tx_upd.gap = !tx_frame_active;
  assign tx_upd.force_load = transmitter_soft_reset;
  // a write during reception waits for the next gap, so only later frames see it
  assign flt_upd.staged = {fmode, tab1, tab0, uni1, uni0};
  assign flt_upd.gap = !rx_frame_active;
  assign flt_upd.force_load = 1'b0;

  ecr_apply #(.W(64), .DEFAULT({RX1_DEFAULT & MASK_RX1, RX0_DEFAULT})) u_rx_apply (
    .ref_clk(ref_clk),
    .rst(rst),
    .upd(rx_upd)
  );

  ecr_apply #(.W(64), .DEFAULT({FLOW_DEFAULT & MASK_FLOW, TX_DEFAULT & MASK_TX})) u_tx_apply (
    .ref_clk(ref_clk),
    .rst(rst),
    .upd(tx_upd)
  );

  ecr_apply #(.W(160), .DEFAULT('0)) u_flt_apply (
    .ref_clk(ref_clk),
    .rst(rst),
    .upd(flt_upd)
  );

  // first wire byte lands in bits [7:0]
  assign pause_station_address = {rx_upd.active[32 +: PAUSE_HI_W], rx_upd.active[31:0]};
  assign control_frame_length_check_off = rx_upd.active[32 + BIT_CTRL_LEN];
  assign length_type_check_off = rx_upd.active[32 + BIT_LT];
  assign receive_half_duplex = rx_upd.active[32 + BIT_HD];
  assign receive_tagged_frames_on = rx_upd.active[32 + BIT_VLAN];
  assign receiver_on = rx_upd.active[32 + BIT_EN];
  assign receive_pass_checksum = rx_upd.active[32 + BIT_FCS];
  assign receive_oversize_frames_on = rx_upd.active[32 + BIT_JUMBO];
  assign transmit_gap_adjust_on = tx_upd.active[BIT_IFG];
  assign transmit_half_duplex = tx_upd.active[BIT_HD];
  assign transmit_tagged_frames_on = tx_upd.active[BIT_VLAN];
  assign transmitter_on = tx_upd.active[BIT_EN];
  assign transmit_client_checksum = tx_upd.active[BIT_FCS];
  assign transmit_oversize_frames_on = tx_upd.active[BIT_JUMBO];
  assign rx_flow_ctrl_on = tx_upd.active[32 + BIT_RXFLOW];
  assign tx_flow_ctrl_on = tx_upd.active[32 + BIT_TXFLOW];
  assign station_unicast_address = flt_upd.active[47:0];
  assign extra_table_word0 = flt_upd.active[95:64];
  assign extra_table_word1 = flt_upd.active[127:96];
  assign filter_mode = flt_upd.active[159:128];
  assign mac_mode = mode;
  assign phy_link = phy;
  assign mgmt = mg;

  ecr_gap_sample #(.DW(GAP_W)) u_gap (
    .ref_clk(ref_clk),
    .rst(rst),
    .clear(transmitter_soft_reset),
    .frame_start(tx_frame_start),
    .adjust_on(transmit_gap_adjust_on),
    .half_duplex(transmit_half_duplex),
    .delay_in(client_gap_delay_value),
    .gap_delay(tx_gap_delay)
  );

  sequence rx1_write_in_gap;
    host_wr && host_addr == OFF_RX1 && !host_wdata[BIT_RST] && !rx_frame_active;
  endsequence

  sequence rx0_write_in_gap;
    host_wr && host_addr == OFF_RX0 && !rx_frame_active;
  endsequence

  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    host_rd && !hit |=> host_rd_valid && host_rdata == DEF_ZERO)
    else $error("unmapped read did not return zero");

  rx_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    rx_frame_active && !receiver_soft_reset |=> $stable(receiver_on) && $stable(receive_oversize_frames_on))
    else $error("receiver setting changed inside a frame");

  rx_apply_a: assert property (@(posedge ref_clk) disable iff (rst)
    rx1_write_in_gap ##1 !rx_frame_active && !receiver_soft_reset |=> receiver_on == $past(host_wdata[BIT_EN], 2))
    else $error("receiver enable not applied in gap");

  pause_low_a: assert property (@(posedge ref_clk) disable iff (rst)
    rx0_write_in_gap ##1 !rx_frame_active && !receiver_soft_reset
      |=> pause_station_address[31:0] == $past(host_wdata, 2))
    else $error("pause address low word not applied");

  rx_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_rx_rst |=> receiver_soft_reset ##1 (receiver_on == RX1_DEFAULT[BIT_EN] && !receiver_soft_reset))
    else $error("receiver soft reset did not restore defaults");

  tx_reset_a: assert property (@(posedge ref_clk) disable iff (rst)
    wr_tx_rst |=> transmitter_soft_reset ##1 (transmitter_on == TX_DEFAULT[BIT_EN] && tx_gap_delay == '0))
    else $error("transmitter soft reset did not restore defaults");

  reserved_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    host_rd && host_addr == OFF_RX1 |=> host_rdata[BIT_RST] == 1'b0 && host_rdata[23:16] == 8'h00)
    else $error("reserved receiver bits read nonzero");

  filter_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    rx_frame_active [*2] |-> $stable(station_unicast_address))
    else $error("filter address changed during reception");

  gap_sample_a: assert property (@(posedge ref_clk) disable iff (rst)
    tx_frame_start && !transmitter_soft_reset && transmit_gap_adjust_on && !transmit_half_duplex
      |=> tx_gap_delay == $past(client_gap_delay_value))
    else $error("gap delay not sampled at frame start");

  sequence tx_write_in_gap;
    host_wr && host_addr == OFF_TX && !host_wdata[BIT_RST] && !tx_frame_active;
  endsequence

  sequence fmode_write_in_gap;
    host_wr && host_addr == OFF_FMODE && !rx_frame_active;
  endsequence

  tx_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    tx_frame_active && !transmitter_soft_reset |=> $stable(transmitter_on) && $stable(tx_flow_ctrl_on))
    else $error("transmitter setting changed inside a frame");

  tx_apply_a: assert property (@(posedge ref_clk) disable iff (rst)
    tx_write_in_gap ##1 !tx_frame_active && !transmitter_soft_reset
      |=> transmitter_on == $past(host_wdata[BIT_EN], 2))
    else $error("transmitter enable not applied in gap");

  filter_apply_a: assert property (@(posedge ref_clk) disable iff (rst)
    fmode_write_in_gap ##1 !rx_frame_active |=> filter_mode == $past(host_wdata, 2))
    else $error("filter mode not applied in gap");

  rx_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    receiver_soft_reset |-> $past(wr_rx_rst))
    else $error("receiver reset pulse without a reset write");

  tx_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    transmitter_soft_reset |-> $past(wr_tx_rst))
    else $error("transmitter reset pulse without a reset write");

  mode_direct_a: assert property (@(posedge ref_clk) disable iff (rst)
    host_wr && host_addr == OFF_MODE |=> mac_mode == $past(host_wdata))
    else $error("mode register did not follow the write");

  read_valid_a: assert property (@(posedge ref_clk) disable iff (rst)
    host_rd |=> host_rd_valid)
    else $error("read not answered one cycle later");

  valid_pulse_a: assert property (@(posedge ref_clk) disable iff (rst)
    !host_rd |=> !host_rd_valid)
    else $error("read answer without a read strobe");

  gap_half_a: assert property (@(posedge ref_clk) disable iff (rst)
    tx_frame_start && !transmitter_soft_reset && transmit_half_duplex |=> tx_gap_delay == '0)
    else $error("gap delay taken in half duplex");
endmodule

// ### ecr_host_model.sv
/*
  host side model: issues single-cycle write and read strobes on ref_clk.
  assumes the bank answers a read with host_rd_valid one cycle after the strobe.
*/
module ecr_host_model
  import ecr_pkg::*;
(
  input wire logic ref_clk,
  output logic [ADDR_W-1:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [DATA_W-1:0] host_wdata,
  input wire logic [DATA_W-1:0] host_rdata,
  input wire logic host_rd_valid
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    host_addr = '0;
    host_wr = 1'b0;
    host_rd = 1'b0;
    host_wdata = '0;
  end
  // idle address and data are inverted so a stale value is never mistaken for a live one
  task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk);
    #1;
    host_addr = a;
    host_wdata = d;
    host_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    host_wr = 1'b0;
    host_addr = ~a;
    host_wdata = ~d;
  endtask
  task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d, output logic ok);
    @(posedge ref_clk);
    #1;
    host_addr = a;
    host_rd = 1'b1;
    @(posedge ref_clk);
    #1;
    host_rd = 1'b0;
    host_addr = ~a;
    ok = host_rd_valid;
    d = host_rdata;
  endtask
endmodule

// ### test_ethernet_mac_config_regs.sv
/*
  self-checking bench for the mac configuration register bank.
  assumes ecr_host_model drives the host strobes; frame activity is driven here.
*/
module test_ethernet_mac_config_regs
  import ecr_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [31:0] PAT = 32'h6A5C_3E1F;
  logic ref_clk, rst, host_wr, host_rd, host_rd_valid;
  logic [ADDR_W-1:0] host_addr;
  logic [DATA_W-1:0] host_wdata, host_rdata;
  logic rx_frame_active, tx_frame_active, tx_frame_start;
  logic [GAP_W-1:0] client_gap_delay_value, tx_gap_delay;
  logic [47:0] pause_station_address, station_unicast_address;
  logic control_frame_length_check_off, length_type_check_off, receive_half_duplex;
  logic receive_tagged_frames_on, receiver_on, receive_pass_checksum, receive_oversize_frames_on;
  logic receiver_soft_reset, transmit_gap_adjust_on, transmit_half_duplex, transmit_tagged_frames_on;
  logic transmitter_on, transmit_client_checksum, transmit_oversize_frames_on, transmitter_soft_reset;
  logic rx_flow_ctrl_on, tx_flow_ctrl_on;
  logic [31:0] extra_table_word0, extra_table_word1, filter_mode, mac_mode, phy_link, mgmt;
  int err_count = 0;
  int num_checks = 0;
  wire [6:0] rx_bits = {receive_oversize_frames_on, receive_pass_checksum, receiver_on,
    receive_tagged_frames_on, receive_half_duplex, length_type_check_off, control_frame_length_check_off};
  wire [5:0] tx_bits = {transmit_oversize_frames_on, transmit_client_checksum, transmitter_on,
    transmit_tagged_frames_on, transmit_half_duplex, transmit_gap_adjust_on};

  ecr_mac_cfg u_dut (.ref_clk, .rst, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
    .host_rd_valid, .rx_frame_active, .tx_frame_active, .tx_frame_start, .client_gap_delay_value,
    .pause_station_address, .control_frame_length_check_off, .length_type_check_off,
    .receive_half_duplex, .receive_tagged_frames_on, .receiver_on, .receive_pass_checksum,
    .receive_oversize_frames_on, .receiver_soft_reset, .transmit_gap_adjust_on, .transmit_half_duplex,
    .transmit_tagged_frames_on, .transmitter_on, .transmit_client_checksum,
    .transmit_oversize_frames_on, .transmitter_soft_reset, .tx_gap_delay, .rx_flow_ctrl_on,
    .tx_flow_ctrl_on, .station_unicast_address, .extra_table_word0, .extra_table_word1,
    .filter_mode, .mac_mode, .phy_link, .mgmt);
  ecr_host_model u_host (.ref_clk, .host_addr, .host_wr, .host_rd, .host_wdata, .host_rdata,
    .host_rd_valid);

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string n, input logic [47:0] s, input logic [47:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic rdchk(input string n, input logic [9:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic ok;
    u_host.read(a, d, ok);
    chk({n, " valid"}, {47'd0, ok}, 48'h1);
    chk(n, {16'd0, d}, {16'd0, e});
  endtask
  task automatic pulse(input logic [7:0] v);
    tx_frame_start = 1'b1;
    client_gap_delay_value = v;
    tick(1);
    tx_frame_start = 1'b0;
    client_gap_delay_value = ~v;
  endtask

  task automatic t_reset();
    rdchk("rx1 default", OFF_RX1, DEF_RX1);
    rdchk("tx default", OFF_TX, DEF_TX);
    chk("rx on", receiver_on, 1);
    chk("tx on", transmitter_on, 1);
    $display("done reset");
  endtask
  task automatic t_map();
    logic [9:0] offs [12] = '{OFF_RX0, OFF_RX1, OFF_TX, OFF_FLOW, OFF_MODE, OFF_PHY, OFF_MGMT,
      OFF_UNI0, OFF_UNI1, OFF_TAB0, OFF_TAB1, OFF_FMODE};
    logic [31:0] masks [12] = '{1: MASK_RX1, 2: MASK_TX, 3: MASK_FLOW, default: 32'hFFFF_FFFF};
    for (int i = 0; i < 12; i++) begin
      u_host.write(offs[i], PAT + i);
    end
    for (int i = 0; i < 12; i++) begin
      rdchk("map", offs[i], (PAT + i) & masks[i]);
    end
    u_host.write(10'h204, PAT);
    rdchk("unmapped", 10'h204, 32'h0000_0000);
    chk("mode", mac_mode, PAT + 4);
    chk("phy", phy_link, PAT + 5);
    chk("mgmt", mgmt, PAT + 6);
    chk("table 0", extra_table_word0, PAT + 9);
    chk("table 1", extra_table_word1, PAT + 10);
    $display("done map");
  endtask
  task automatic t_rx();
    logic [31:0] w [2] = '{32'h5500_FFEE, 32'h2A00_FFEE};
    for (int i = 0; i < 2; i++) begin
      rx_frame_active = 1'b1;
      u_host.write(OFF_RX0, 32'hDDCC_BBAA);
      u_host.write(OFF_RX1, w[i]);
      u_host.write(OFF_UNI0, 32'hDDCC_BBAA);
      u_host.write(OFF_UNI1, 32'h0000_FFEE);
      u_host.write(OFF_FMODE, w[i]);
      tick(3);
      if (i == 0) begin
        chk("pause held", pause_station_address, 48'h3E20_6A5C_3E1F);
        chk("filter held", filter_mode, PAT + 11);
        chk("rx held", rx_bits, 7'h6A);
      end
      rx_frame_active = 1'b0;
      tick(2);
      chk("pause", pause_station_address, 48'hFFEE_DDCC_BBAA);
      chk("unicast", station_unicast_address, 48'hFFEE_DDCC_BBAA);
      chk("filter", filter_mode, w[i]);
      chk("rx fields", rx_bits, w[i][30:24]);
    end
    $display("done rx");
  endtask
  task automatic t_tx();
    tx_frame_active = 1'b1;
    u_host.write(OFF_TX, 32'h5400_0000);
    u_host.write(OFF_FLOW, 32'h0000_0000);
    tick(3);
    chk("tx held", tx_bits, 6'h35);
    chk("flow held", {rx_flow_ctrl_on, tx_flow_ctrl_on}, 2'b11);
    tx_frame_active = 1'b0;
    tick(2);
    chk("tx fields", tx_bits, 6'h2A);
    chk("flow", {rx_flow_ctrl_on, tx_flow_ctrl_on}, 2'b00);
    u_host.write(OFF_TX, 32'h2A00_0000);
    tick(2);
    chk("tx fields 2", tx_bits, 6'h15);
    $display("done tx");
  endtask
  task automatic t_gap();
    u_host.write(OFF_TX, 32'h1200_0000);
    tick(2);
    pulse(8'h5A);
    chk("gap", tx_gap_delay, 8'h5A);
    client_gap_delay_value = 8'h33;
    tick(3);
    chk("gap kept", tx_gap_delay, 8'h5A);
    u_host.write(OFF_TX, 32'h1600_0000);
    tick(2);
    pulse(8'h77);
    chk("gap half", tx_gap_delay, 8'h00);
    u_host.write(OFF_TX, 32'h1200_0000);
    tick(2);
    pulse(8'hC3);
    chk("gap again", tx_gap_delay, 8'hC3);
    $display("done gap");
  endtask
  // soft reset in mid-frame, other written bits set too; they must not land
  task automatic t_srst(input logic [9:0] a, input bit is_rx);
    int n;
    rx_frame_active = 1'b1;
    tx_frame_active = 1'b1;
    u_host.write(a, 32'hFFFF_FFFF);
    n = 0;
    for (int k = 0; k < 4; k++) begin
      if ((is_rx ? receiver_soft_reset : transmitter_soft_reset) === 1'b1) n++;
      tick(1);
    end
    chk("reset pulses", n, 1);
    if (is_rx) begin
      chk("rx reset", rx_bits, DEF_RX1[30:24]);
      chk("pause reset", pause_station_address, 48'h0);
      chk("filter kept", station_unicast_address, 48'hFFEE_DDCC_BBAA);
      rdchk("rx1 clear", OFF_RX1, DEF_RX1);
    end else begin
      chk("tx reset", tx_bits, DEF_TX[30:25]);
      chk("gap reset", tx_gap_delay, 8'h00);
      rdchk("tx clear", OFF_TX, DEF_TX);
    end
    rx_frame_active = 1'b0;
    tx_frame_active = 1'b0;
    $display("done soft reset");
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    rst = 1'b1;
    rx_frame_active = 1'b0;
    tx_frame_active = 1'b0;
    tx_frame_start = 1'b0;
    client_gap_delay_value = 8'h00;
    tick(2);
    rst = 1'b0;
    t_reset();
    t_map();
    t_rx();
    t_tx();
    t_gap();
    t_srst(OFF_RX1, 1'b1);
    t_srst(OFF_TX, 1'b0);
    give_verdict();
  end
endmodule
